// file: option_cfg_pkg.sv
// option_cfg_pkg: addresses, reset values, load states, carriers and
// size decoders shared by the start-up option loader and its bench.
// assumes a 16-bit byte address space shared by flash and special registers.
package option_cfg_pkg;

    // option byte locations in flash, primary copies
    localparam logic [15:0] POC_OPT_ADDR    = 16'h0081;
    localparam logic [15:0] RSVD_A_ADDR     = 16'h0082;
    localparam logic [15:0] RSVD_B_ADDR     = 16'h0083;
    localparam logic [15:0] DBG_OPT_ADDR    = 16'h0084;
    // distance from a primary option byte to its boot-swap alternate
    localparam logic [15:0] ALT_OPT_OFFSET  = 16'h1000;
    // memory size register in the special register space
    localparam logic [15:0] MEM_SIZE_ADDR   = 16'hFFF0;
    localparam logic [7:0]  MEM_SIZE_RESET  = 8'hCF;
    // field positions
    localparam int          LEVEL_BIT       = 0;
    localparam int          RAM_FIELD_LSB   = 4;
    localparam int          ROM_FIELD_LSB   = 0;
    // debug control codes
    localparam logic [1:0]  DBG_OFF         = 2'h0;
    localparam logic [1:0]  DBG_BAD         = 2'h1;
    localparam logic [1:0]  DBG_KEEP        = 2'h2;
    localparam logic [1:0]  DBG_ERASE       = 2'h3;
    // decoded sizes
    localparam logic [10:0] RAM_768         = 11'h300;
    localparam logic [10:0] RAM_512         = 11'h200;
    localparam logic [10:0] RAM_1024        = 11'h400;

    // loader states, gray coded along the boot-swap load path
    typedef enum logic [2:0]
    {
        LD_POC  = 3'h0,
        LD_DBG  = 3'h1,
        CP_POC  = 3'h3,
        CP_DBG  = 3'h2,
        LD_DONE = 3'h6
    } load_state_e;

    // one flash write request
    typedef struct packed
    {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } flash_wreq_s;

    // decoded start-up settings
    typedef struct packed
    {
        logic dual_poc;
        logic debug_en;
        logic debug_erase;
        logic debug_bad;
        logic opt_fault;
    } option_cfg_s;

    // store index of an option address 0081..0084 -> 0..3
    function automatic logic [1:0] opt_index(input logic [15:0] a);
        opt_index = a[1:0] - 2'h1;
    endfunction

    // true for either copy of the level-select option byte
    function automatic logic is_level_addr(input logic [15:0] a);
        is_level_addr = (a == POC_OPT_ADDR) || (a == 16'(POC_OPT_ADDR + ALT_OPT_OFFSET));
    endfunction

    // working memory size in bytes, zero for a prohibited code
    function automatic logic [10:0] ram_bytes(input logic [2:0] c);
        if (c == 3'h0)
            ram_bytes = RAM_768;
        else if (c == 3'h2)
            ram_bytes = RAM_512;
        else if (c == 3'h6)
            ram_bytes = RAM_1024;
        else
            ram_bytes = 11'h000;
    endfunction

    // program store size in KB, zero for a prohibited code
    function automatic logic [5:0] rom_kb(input logic [3:0] c);
        case (c)
            4'h2:    rom_kb = 6'h08;
            4'h4:    rom_kb = 6'h10;
            4'h6:    rom_kb = 6'h18;
            4'h8:    rom_kb = 6'h20;
            4'hC:    rom_kb = 6'h30;
            4'hF:    rom_kb = 6'h3C;
            default: rom_kb = 6'h00;
        endcase
    endfunction

endpackage

// file: option_store.sv
// option_store: small byte store holding the option bytes as loaded.
// assumes one writer and one reader; read data appear one clock later.
`timescale 1ns/1ns
module option_store
#(
    parameter int DEPTH = 4,
    parameter int WIDTH = 8
)
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_b,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [WIDTH-1:0]         wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [WIDTH-1:0]         rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // storage, cleared on reset so reserved entries read zero
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= '0;
        end
        else if (wr_en)
            mem[wr_idx] <= wr_data;
    end

    // registered read port
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data <= '0;
        else
            rd_data <= mem[rd_idx];
    end

endmodule // option_store

// file: option_byte_memory_config.sv
// option_byte_memory_config: start-up option byte loader, option write
// guard and memory size register.
// assumes flash read data valid one clock after flash_rd, and a cpu
// memory port with one-cycle read latency.
`timescale 1ns/1ns
module option_byte_memory_config
(
    input  wire logic                        core_clk,
    input  wire logic                        rst_b,
    // flash read port used by the loader
    output logic                             flash_rd,
    output logic [15:0]                      flash_raddr,
    input  wire logic [7:0]                  flash_rdata,
    input  wire logic                        boot_swap,
    // flash write requests
    input  wire logic                        programmer_wr,
    input  wire logic [15:0]                 programmer_addr,
    input  wire logic [7:0]                  programmer_wdata,
    input  wire logic                        chip_erase,
    input  wire logic                        block_erase,
    input  wire logic                        selfprog_wr,
    input  wire logic [15:0]                 selfprog_addr,
    input  wire logic [7:0]                  selfprog_wdata,
    output option_cfg_pkg::flash_wreq_s      flash_wreq,
    output logic                             write_refused,
    // cpu memory port
    input  wire logic                        mem_wr,
    input  wire logic                        mem_rd,
    input  wire logic [15:0]                 mem_addr,
    input  wire logic [7:0]                  mem_wdata,
    output logic [7:0]                       mem_rdata,
    // decoded results
    output option_cfg_pkg::option_cfg_s      cfg,
    output logic                             cfg_done,
    output logic [10:0]                      ram_size_bytes,
    output logic [5:0]                       rom_size_kb,
    output logic                             mem_size_bad
);

    option_cfg_pkg::load_state_e state;
    option_cfg_pkg::load_state_e next_state;
    logic                        pend;
    logic [7:0]                  poc_byte;
    logic [7:0]                  dbg_byte;
    logic [7:0]                  memory_size_register;
    logic [7:0]                  size_q;
    logic                        chip_erased;
    logic                        rd_size;
    logic                        rd_opt;
    logic [7:0]                  store_q;
    logic [15:0]                 primary_addr;
    logic                        loading;
    logic                        capture;
    logic                        copy_req;
    logic                        prog_ok;
    logic                        self_ok;
    logic                        prog_level_ok;
    logic                        opt_read;
    option_cfg_pkg::flash_wreq_s copy_wreq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    ////////////////////////////////////////////////////////////////////////
    // loader sequencing

    // address of the byte the loader is working on
    assign primary_addr = (state == option_cfg_pkg::LD_POC || state == option_cfg_pkg::CP_POC)
                          ? option_cfg_pkg::POC_OPT_ADDR : option_cfg_pkg::DBG_OPT_ADDR;
    assign loading      = (state == option_cfg_pkg::LD_POC) || (state == option_cfg_pkg::LD_DBG);
    assign capture      = loading && pend;
    assign flash_rd     = loading && !pend;
    assign flash_raddr  = boot_swap ? 16'(primary_addr + option_cfg_pkg::ALT_OPT_OFFSET)
                                    : primary_addr;
    assign cfg_done     = (state == option_cfg_pkg::LD_DONE);

    // next state: read both bytes, then copy them back when swapped
    always_comb
    begin
        next_state = state;
        case (state)
            option_cfg_pkg::LD_POC:
                if (pend)
                    next_state = option_cfg_pkg::LD_DBG;
            option_cfg_pkg::LD_DBG:
                if (pend)
                    next_state = boot_swap ? option_cfg_pkg::CP_POC
                                           : option_cfg_pkg::LD_DONE;
            option_cfg_pkg::CP_POC:
                next_state = option_cfg_pkg::CP_DBG;
            option_cfg_pkg::CP_DBG:
                next_state = option_cfg_pkg::LD_DONE;
            default:
                next_state = option_cfg_pkg::LD_DONE;
        endcase
    end

    // state and read-wait flag; load starts at reset release
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= option_cfg_pkg::LD_POC;
            pend  <= 1'b0;
        end
        else
        begin
            state <= next_state;
            pend  <= flash_rd;
        end
    end

    // capture raw bytes and decoded settings, held until next reset
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            poc_byte <= 8'h00;
            dbg_byte <= 8'h00;
            cfg      <= '0;
        end
        else if (capture && state == option_cfg_pkg::LD_POC)
        begin
            poc_byte      <= flash_rdata;
            cfg.dual_poc  <= flash_rdata[option_cfg_pkg::LEVEL_BIT];
            cfg.opt_fault <= cfg.opt_fault | (flash_rdata[7:1] != 7'h00);
        end
        else if (capture)
        begin
            dbg_byte        <= flash_rdata;
            cfg.debug_en    <= flash_rdata[1];
            cfg.debug_erase <= (flash_rdata[1:0] == option_cfg_pkg::DBG_ERASE);
            cfg.debug_bad   <= (flash_rdata[1:0] == option_cfg_pkg::DBG_BAD);
            cfg.opt_fault   <= cfg.opt_fault | (flash_rdata[7:2] != 6'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flash write arbitration and option guard

    // boot-swap copy of the loaded alternate into the primary location
    assign copy_req       = (state == option_cfg_pkg::CP_POC) || (state == option_cfg_pkg::CP_DBG);
    assign copy_wreq      = '{valid: copy_req, addr: primary_addr,
                              data: (state == option_cfg_pkg::CP_POC) ? poc_byte : dbg_byte};
    assign prog_level_ok  = !option_cfg_pkg::is_level_addr(programmer_addr) || chip_erased;
    assign prog_ok        = programmer_wr && prog_level_ok && !copy_req;
    assign self_ok        = selfprog_wr && !programmer_wr && !copy_req
                            && !option_cfg_pkg::is_level_addr(selfprog_addr);
    assign write_refused  = (programmer_wr && !prog_ok) || (selfprog_wr && !self_ok);

    // priority: swap copy, then programmer, then self-programming
    always_comb
    begin
        if (copy_req)
            flash_wreq = copy_wreq;
        else if (prog_ok)
            flash_wreq = '{valid: 1'b1, addr: programmer_addr, data: programmer_wdata};
        else if (self_ok)
            flash_wreq = '{valid: 1'b1, addr: selfprog_addr, data: selfprog_wdata};
        else
            flash_wreq = '0;
    end

    // chip erase opens one level byte rewrite; block erase does not
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            chip_erased <= 1'b0;
        else if (chip_erase)
            chip_erased <= 1'b1;
        else if (prog_ok && option_cfg_pkg::is_level_addr(programmer_addr))
            chip_erased <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // memory size register and cpu read path

    // byte-wide register, reset value loaded on every reset
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            memory_size_register <= option_cfg_pkg::MEM_SIZE_RESET;
        else if (mem_wr && mem_addr == option_cfg_pkg::MEM_SIZE_ADDR)
            memory_size_register <= mem_wdata;
    end

    // size decode, zero plus flag for prohibited codes
    assign ram_size_bytes = option_cfg_pkg::ram_bytes(memory_size_register[6:4]);
    assign rom_size_kb    = option_cfg_pkg::rom_kb(memory_size_register[3:0]);
    assign mem_size_bad   = (ram_size_bytes == 11'h000) || (rom_size_kb == 6'h00) ||
                            memory_size_register[7];

    // read selects; option bytes come back from the store
    assign opt_read = mem_rd && (mem_addr >= option_cfg_pkg::POC_OPT_ADDR)
                      && (mem_addr <= option_cfg_pkg::DBG_OPT_ADDR);
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_size <= 1'b0;
            rd_opt  <= 1'b0;
            size_q  <= 8'h00;
        end
        else
        begin
            rd_size <= mem_rd && (mem_addr == option_cfg_pkg::MEM_SIZE_ADDR);
            rd_opt  <= opt_read;
            size_q  <= memory_size_register;
        end
    end

    // unmapped reads return zero
    assign mem_rdata = rd_size ? size_q : (rd_opt ? store_q : 8'h00);

    option_store #(.DEPTH(4), .WIDTH(8)) u_store
    (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .wr_en    (capture),
        .wr_idx   (option_cfg_pkg::opt_index(primary_addr)),
        .wr_data  (flash_rdata),
        .rd_idx   (option_cfg_pkg::opt_index(mem_addr)),
        .rd_data  (store_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_read_level;
        state == option_cfg_pkg::LD_POC && flash_rd ##1 capture;
    endsequence

    a_level_decode: assert property (s_read_level
        |=> cfg.dual_poc == $past(flash_rdata[0]))
        else $error("level select not taken from option byte bit 0");

    a_self_guard: assert property (selfprog_wr && option_cfg_pkg::is_level_addr(selfprog_addr)
        |-> !(flash_wreq.valid && flash_wreq.addr == selfprog_addr) && write_refused)
        else $error("self-programming wrote the level option byte");

    sequence s_swap_loaded;
        state == option_cfg_pkg::LD_DBG && capture && boot_swap;
    endsequence

    a_swap_copy: assert property (s_swap_loaded |=> flash_wreq.valid
        && flash_wreq.addr == option_cfg_pkg::POC_OPT_ADDR ##1 flash_wreq.valid
        && flash_wreq.addr == option_cfg_pkg::DBG_OPT_ADDR && flash_wreq.data == dbg_byte)
        else $error("boot swap copy missing or wrong");

    a_erase_gate: assert property (programmer_wr && !chip_erased
        && option_cfg_pkg::is_level_addr(programmer_addr) |-> write_refused && !prog_ok)
        else $error("level byte rewritten without chip erase");

    a_debug_decode: assert property (state == option_cfg_pkg::LD_DBG && capture |=>
        cfg.debug_en == $past(flash_rdata[1])
        && cfg.debug_bad == ($past(flash_rdata[1:0]) == 2'h1)
        && cfg.debug_erase == ($past(flash_rdata[1:0]) == 2'h3))
        else $error("debug control decode wrong");

    a_size_reset: assert property ($rose(rst_b) |-> memory_size_register == 8'hCF)
        else $error("memory size register reset value wrong");

    a_size_write: assert property (mem_wr && mem_addr == option_cfg_pkg::MEM_SIZE_ADDR
        |=> memory_size_register == $past(mem_wdata))
        else $error("memory size register write lost");

    a_size_readback: assert property (mem_rd && mem_addr == option_cfg_pkg::MEM_SIZE_ADDR
        |=> mem_rdata == $past(memory_size_register))
        else $error("memory size register read back wrong");

    a_ram_decode: assert property (
        (memory_size_register[6:4] == 3'h6 |-> ram_size_bytes == 11'd1024)
        and (memory_size_register[6:4] == 3'h1 |-> ram_size_bytes == 11'h000))
        else $error("ram size decode wrong");

    a_rom_decode: assert property ((memory_size_register[3:0] == 4'hF |-> rom_size_kb == 6'd60)
        and (memory_size_register[3:0] == 4'hC |-> rom_size_kb == 6'd48))
        else $error("rom size decode wrong");

    a_hold_cfg: assert property (cfg_done |=> cfg_done && $stable(cfg))
        else $error("loaded settings changed before reset");

endmodule // option_byte_memory_config

// file: tb_option_byte_memory_config.sv
// tb_option_byte_memory_config: self-checking bench for the option loader,
// write guard and memory size register.
// assumes the bench stands in for flash, programmer, self-programming and cpu.
`timescale 1ns/1ns
module tb_option_byte_memory_config;

    logic                        core_clk = 1'b0;
    logic                        rst_b = 1'b0;
    logic                        flash_rd;
    logic [15:0]                 flash_raddr;
    logic [7:0]                  flash_rdata = 8'h00;
    logic                        boot_swap = 1'b0;
    logic                        programmer_wr = 1'b0;
    logic [15:0]                 programmer_addr = 16'h0000;
    logic [7:0]                  programmer_wdata = 8'h00;
    logic                        chip_erase = 1'b0;
    logic                        block_erase = 1'b0;
    logic                        selfprog_wr = 1'b0;
    logic [15:0]                 selfprog_addr = 16'h0000;
    logic [7:0]                  selfprog_wdata = 8'h00;
    option_cfg_pkg::flash_wreq_s flash_wreq;
    logic                        write_refused;
    logic                        mem_wr = 1'b0;
    logic                        mem_rd = 1'b0;
    logic [15:0]                 mem_addr = 16'h0000;
    logic [7:0]                  mem_wdata = 8'h00;
    logic [7:0]                  mem_rdata;
    option_cfg_pkg::option_cfg_s cfg;
    logic                        cfg_done;
    logic [10:0]                 ram_size_bytes;
    logic [5:0]                  rom_size_kb;
    logic                        mem_size_bad;
    int                          errors = 0;
    int                          n_compared = 0;
    int                          cycles = 0;
    logic [7:0]                  img [4];
    option_cfg_pkg::flash_wreq_s copies [$];
    logic [2:0]                  ram_ok [3] = '{3'h0, 3'h2, 3'h6};

    option_byte_memory_config i_dut
    (
        .core_clk, .rst_b, .flash_rd, .flash_raddr, .flash_rdata, .boot_swap,
        .programmer_wr, .programmer_addr, .programmer_wdata, .chip_erase, .block_erase,
        .selfprog_wr, .selfprog_addr, .selfprog_wdata, .flash_wreq, .write_refused,
        .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_rdata, .cfg, .cfg_done,
        .ram_size_bytes, .rom_size_kb, .mem_size_bad
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, flash stand-in and hang guard
    always #10 core_clk = ~core_clk;

    // data one clock after the strobe, a shifting pattern when not read
    always @(posedge core_clk)
    begin
        if (flash_rd)
            flash_rdata <= #2 img[{flash_raddr[12], flash_raddr[2]}];
        else
            flash_rdata <= #2 {flash_rdata[6:0], ~flash_rdata[7]};
    end

    // cut a hang short
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // expectations and helpers
    function automatic logic [10:0] exp_ram(input logic [2:0] c);
        case (c)
            3'h0:    return 11'h300;
            3'h2:    return 11'h200;
            3'h6:    return 11'h400;
            default: return 11'h000;
        endcase
    endfunction

    function automatic logic [5:0] exp_rom(input logic [3:0] c);
        case (c)
            4'h2:    return 6'h08;
            4'h4:    return 6'h10;
            4'h6:    return 6'h18;
            4'h8:    return 6'h20;
            4'hC:    return 6'h30;
            4'hF:    return 6'h3C;
            default: return 6'h00;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // reset with a given flash image, then follow the load to its end
    task automatic do_load(input logic [7:0] lp, dp, la, da, input logic sw);
        img = '{lp, dp, la, da};
        @(posedge core_clk);
        #2;
        rst_b = 1'b0;
        boot_swap = sw;
        repeat (3) @(posedge core_clk);
        #2;
        chk({cfg, cfg_done, mem_size_bad}, {5'h00, 1'b0, 1'b1});
        rst_b = 1'b1;
        copies = {};
        for (int n = 0; n < 20 && cfg_done !== 1'b1; n++)
        begin
            @(negedge core_clk);
            if (flash_wreq.valid === 1'b1)
                copies.push_back(flash_wreq);
        end
    endtask

    task automatic mem_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #2;
        mem_wr = 1'b1;
        mem_addr = a;
        mem_wdata = d;
        @(posedge core_clk);
        #2;
        mem_wr = 1'b0;
    endtask

    task automatic mem_read(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #2;
        mem_rd = 1'b1;
        mem_addr = a;
        @(posedge core_clk);
        #2;
        mem_rd = 1'b0;
        d = mem_rdata;
    endtask

    // one cycle of flash write requests, checked before the next edge
    task automatic wr_step(input logic pw, input logic [15:0] pa, input logic sp,
                           input logic [15:0] sa, input logic ce, input logic be,
                           input logic v, input logic [15:0] a, input logic rf);
        @(posedge core_clk);
        #2;
        programmer_wr = pw;
        programmer_addr = pa;
        programmer_wdata = pa[7:0] ^ 8'h5A;
        selfprog_wr = sp;
        selfprog_addr = sa;
        selfprog_wdata = sa[7:0] ^ 8'hA5;
        chip_erase = ce;
        block_erase = be;
        @(negedge core_clk);
        chk({flash_wreq.valid, v ? flash_wreq.addr : 16'h0000, write_refused}, {v, a, rf});
        if (v)
            chk(flash_wreq.data, a[7:0] ^ ((pw && a == pa) ? 8'h5A : 8'hA5));
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic       lv;
        logic       sw;
        logic [1:0] dg;
        logic [7:0] lb;
        logic [7:0] db;
        logic [7:0] r;
        logic [7:0] v;
        logic [15:0] pa;
        logic [15:0] sa;
        void'($urandom(24));
        // every debug code, with and without boot swap
        for (int i = 0; i < 8; i++)
        begin
            lv = 1'($urandom % 2);
            dg = i[1:0];
            sw = i[2];
            lb = {7'h00, lv};
            db = {6'h00, dg};
            do_load(sw ? ~lb & 8'h01 : lb, sw ? 8'h00 : db, sw ? lb : ~lb & 8'h01,
                    sw ? db : 8'h00, sw);
            chk(cfg_done, 1'b1);
            chk(cfg, {lv, dg[1], dg == 2'h3, dg == 2'h1, 1'b0});
            chk(copies.size(), sw ? 2 : 0);
            if (sw)
            begin
                chk(copies[0], {1'b1, 16'h0081, lb});
                chk(copies[1], {1'b1, 16'h0084, db});
            end
        end
        // upper level bits set: flagged, level still decoded
        do_load(8'h81, 8'h02, 8'h00, 8'h02, 1'b0);
        chk(cfg, {1'b1, 1'b1, 1'b0, 1'b0, 1'b1});
        // loaded option bytes read back, reserved 0082 reads zero
        mem_read(16'h0081, r);
        chk(r, 8'h81);
        mem_read(16'h0082, r);
        chk(r, 8'h00);
        mem_read(16'h0084, r);
        chk(r, 8'h02);
        mem_read(16'hFFF0, r);
        chk(r, 8'hCF);
        mem_read(16'h1234, r);
        chk(r, 8'h00);
        // every rom code, legal and random ram codes, one bit 7 case
        for (int k = 0; k < 32; k++)
        begin
            v = {k == 5, k >= 16 ? 3'($urandom % 8) : ram_ok[k % 3], 4'(k)};
            mem_write(16'hFFF0, v);
            mem_write(16'h1234, ~v);
            mem_read(16'hFFF0, r);
            chk(r, v);
            chk(ram_size_bytes, exp_ram(v[6:4]));
            chk(rom_size_kb, exp_rom(v[3:0]));
            chk(mem_size_bad, v[7] || exp_ram(v[6:4]) == 0 || exp_rom(v[3:0]) == 0);
        end
        // level byte guard: self-programming never, programmer after chip erase once
        wr_step(1'b0, 16'h0000, 1'b1, 16'h0081, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
        wr_step(1'b0, 16'h0000, 1'b1, 16'h1081, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
        wr_step(1'b1, 16'h0081, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
        wr_step(1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b0, 16'h0000, 1'b0);
        wr_step(1'b1, 16'h0081, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
        wr_step(1'b0, 16'h0000, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b0, 16'h0000, 1'b0);
        wr_step(1'b1, 16'h0081, 1'b1, 16'h0300, 1'b0, 1'b0, 1'b1, 16'h0081, 1'b1);
        wr_step(1'b1, 16'h0081, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
        // ordinary writes pass, programmer ahead of self-programming
        for (int k = 0; k < 12; k++)
        begin
            pa = 16'($urandom) & 16'hFF7F;
            sa = 16'($urandom) & 16'hFF7F;
            wr_step(k[0], pa, 1'b1, sa, 1'b0, 1'b0, 1'b1, k[0] ? pa : sa, k[0]);
        end
        wr_step(1'b0, 16'h0000, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b0);
        chk(cfg, {1'b1, 1'b1, 1'b0, 1'b0, 1'b1});
        end_of_test();
    end

endmodule // tb_option_byte_memory_config
